//--- e1s_regs.svh
/*
 * Register offsets, field positions, reset values and timing figures
 * for the E1 status, mask and error-counter bank.
 * Assumes a 40 MHz mclk and an 8-bit register port.
 */
`ifndef E1S_REGS_SVH
`define E1S_REGS_SVH

// Register offsets
`define E1S_ADDR_VIOL_HI      8'h00
`define E1S_ADDR_VIOL_LO      8'h01
`define E1S_ADDR_CSUM_HI      8'h02
`define E1S_ADDR_CSUM_LO      8'h03
`define E1S_ADDR_EVT_STATUS   8'h07
`define E1S_ADDR_ALARM_MASK   8'h16
`define E1S_ADDR_EVENT_MASK   8'h17
`define E1S_ADDR_CTRL         8'h18

// Control register fields
`define E1S_CTRL_TIMER_RATE   7
`define E1S_CTRL_VIOL_TYPE    6
`define E1S_CTRL_HDB3         2
`define E1S_CTRL_TX_CLOCK_LOST_PIN_EN  1
`define E1S_CTRL_CSUM_EN      0

// Reset values
`define E1S_RST_MASK          8'h00
`define E1S_RST_CTRL          8'h00
`define E1S_RD_ZERO           8'h00

// Timing: clock period, loss-of-transmit-clock time, rx bit counts
`define E1S_MCLK_PERIOD_NS    25
`define E1S_TX_CLOCK_LOST_TIME_NS      3900
`define E1S_TX_CLOCK_LOST_CYC          ((`E1S_TX_CLOCK_LOST_TIME_NS + `E1S_MCLK_PERIOD_NS - 1) / `E1S_MCLK_PERIOD_NS)
`define E1S_SEC_BITS          2048000
`define E1S_SUBSEC_BITS       128000
`define E1S_MF_BITS           4096

`endif

//--- e1s_pkg.sv
/*
 * Types shared by the E1 status, mask and error-counter bank.
 * Assumes the constants header is included where offsets are needed.
 */
`default_nettype none

package e1s_pkg;

   // Decoded receive line symbol, one per received bit
   typedef struct packed {
      logic bit_en;   // one mclk pulse per received bit
      logic pos;      // positive mark on this bit
      logic neg;      // negative mark on this bit
   } e1s_line_t;

   // Control bits held in the control register
   typedef struct packed {
      logic timer_rate;  // 1: 62.5 ms interval, 0: 1 s
      logic viol_type;   // 1: code violations, 0: bipolar violations
      logic hdb3;        // receive side decodes HDB3
      logic tx_clock_lost_pin_en; // lets the lost-clock pin follow the condition
      logic csum_en;     // CRC4 framing enabled
   } e1s_ctrl_t;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } e1s_req_t;

endpackage

`default_nettype wire

//--- e1s_status.sv
/*
 * E1 event status register, two interrupt mask registers, the 16-bit
 * violation counter and the 10-bit CRC4 error counter, with their
 * interval timer and the transmit clock watchdog.
 * Assumes every input is synchronous to mclk; framer pulses are one
 * cycle wide; register reads return data in the following cycle.
 */
// The implementer's own choice: the plain strobed port.
`include "e1s_regs.svh"
`default_nettype none

// Notes on behaviour
// - Timer flag set each second from receive bits, or every 62.5 ms when selected.
// - Transmit align frame flag set every 250 us at each transmitted align frame.
// - Lost transmit clock flag set after one channel time without a transition.
// - Lost clock pin high while condition holds and its enable bit is 1.
// - CRC4 multiframe flag on boundaries; free-running 2 ms when CRC4 disabled.
// - Alarm mask bit gates first status flag at same position; 1 enables.
// - Event mask bit gates event status flag at same position; 1 enables.
// - All counts transfer to readable registers on each timer boundary.
// - Violation count is 16 bits: high byte at 0x00, low byte at 0x01.
// - Violation type 0 counts bipolar violations: two same-polarity marks in a row.
// - With HDB3 decoding, valid substitution violations are not counted.
// - Violation type 1 counts code violations: two same-polarity bipolar violations.
// - Violation counting never stops for loss of sync.
// - Violation count saturates at 65,535 and never wraps.
// - CRC4 submultiframe errors counted in a 10-bit counter.
// - CRC4 counting stops on FAS or CRC4 sync loss, not on CAS loss.
// - CRC4 count bits 9:8 at 0x02 bits 1:0, bits 7:0 at 0x03.
module e1s_status
   import e1s_pkg::*;
#(
   parameter int SEC_BITS    = `E1S_SEC_BITS,
   parameter int SUBSEC_BITS = `E1S_SUBSEC_BITS
) (
   input  wire logic       mclk,
   input  wire logic       reset,
   input  wire e1s_req_t   req,
   output var  logic [7:0] rdata,
   input  wire e1s_line_t  rx_line,
   input  wire logic       tx_clock_input,
   input  wire logic [7:0] alarm_flags,
   input  wire logic       rx_signaling_mf_pulse,
   input  wire logic       rx_align_frame_pulse,
   input  wire logic       tx_mf_pulse,
   input  wire logic       tx_align_frame_pulse,
   input  wire logic       rx_checksum_mf_pulse,
   input  wire logic       tx_slip_pulse,
   input  wire logic       checksum_error_pulse,
   input  wire logic       fas_sync_lost,
   input  wire logic       checksum_sync_lost,
   output var  logic       tx_clock_lost,
   output logic            irq
);

   localparam int TMR_W  = 21;
   localparam int TX_CLOCK_LOST_W = 8;

   logic [7:0]        alarm_mask_q;
   logic [7:0]        event_mask_q;
   e1s_ctrl_t         ctrl_q;
   logic [7:0]        status_q;
   logic [7:0]        status_set;
   logic [7:0]        status_clr;
   logic [TMR_W-1:0]  tmr_q;
   logic              tick;
   logic [11:0]       mf_q;
   logic              free_mf_tick;
   logic              tx_clock_input_prev_q;
   logic [TX_CLOCK_LOST_W-1:0] tx_clock_lost_cnt_q;
   logic              tx_clock_lost_cond;
   logic              last_pol_q;
   logic              have_mark_q;
   logic [2:0]        zeros_q;
   logic              last_v_pol_q;
   logic              have_v_q;
   logic              mark;
   logic              mark_pol;
   logic              bipolar_violation;
   logic              hdb3_sub;
   logic              viol_evt;
   logic [15:0]       viol_acc_q;
   logic [15:0]       viol_acc_inc;
   logic [15:0]       viol_cnt_q;
   logic [9:0]        csum_acc_q;
   logic [9:0]        csum_cnt_q;
   logic              csum_evt;

   // Register writes: the two masks and the control bits
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         alarm_mask_q <= `E1S_RST_MASK;
         event_mask_q <= `E1S_RST_MASK;
         ctrl_q       <= e1s_ctrl_t'(5'(`E1S_RST_CTRL));
      end else if (req.wr) begin
         unique case (req.addr)
            `E1S_ADDR_ALARM_MASK: alarm_mask_q <= req.wdata;
            `E1S_ADDR_EVENT_MASK: event_mask_q <= req.wdata;
            `E1S_ADDR_CTRL: begin
               ctrl_q.timer_rate  <= req.wdata[`E1S_CTRL_TIMER_RATE];
               ctrl_q.viol_type   <= req.wdata[`E1S_CTRL_VIOL_TYPE];
               ctrl_q.hdb3        <= req.wdata[`E1S_CTRL_HDB3];
               ctrl_q.tx_clock_lost_pin_en <= req.wdata[`E1S_CTRL_TX_CLOCK_LOST_PIN_EN];
               ctrl_q.csum_en     <= req.wdata[`E1S_CTRL_CSUM_EN];
            end
            default: ;
         endcase
      end
   end

   // Interval timer counts received bits; the limit follows the rate bit
   // and a compare by >= keeps a mid-interval rate change from overrunning
   always_comb begin
      tick = 1'b0;
      if (rx_line.bit_en) begin
         if (ctrl_q.timer_rate) begin
            tick = (tmr_q >= TMR_W'(SUBSEC_BITS - 1));
         end else begin
            tick = (tmr_q >= TMR_W'(SEC_BITS - 1));
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tmr_q <= '0;
      end else if (tick) begin
         tmr_q <= '0;
      end else if (rx_line.bit_en) begin
         tmr_q <= tmr_q + TMR_W'(1);
      end
   end

   // Free-running 2 ms boundary used when CRC4 framing is off
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         mf_q <= '0;
      end else if (rx_line.bit_en) begin
         mf_q <= mf_q + 12'(1); // wraps every 4096 bits
      end
   end
   assign free_mf_tick = rx_line.bit_en && (mf_q == 12'(`E1S_MF_BITS - 1));

   // Transmit clock watchdog: count mclk cycles since the last edge
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tx_clock_input_prev_q <= 1'b0;
         tx_clock_lost_cnt_q  <= '0;
      end else begin
         tx_clock_input_prev_q <= tx_clock_input;
         if (tx_clock_input != tx_clock_input_prev_q) begin
            tx_clock_lost_cnt_q <= '0;
         end else if (tx_clock_lost_cnt_q != TX_CLOCK_LOST_W'(`E1S_TX_CLOCK_LOST_CYC)) begin
            tx_clock_lost_cnt_q <= tx_clock_lost_cnt_q + TX_CLOCK_LOST_W'(1);
         end
      end
   end
   assign tx_clock_lost_cond = (tx_clock_lost_cnt_q == TX_CLOCK_LOST_W'(`E1S_TX_CLOCK_LOST_CYC));

   // Pin follows the live condition, not the sticky flag, so it drops
   // as soon as the transmit clock returns
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tx_clock_lost <= 1'b0;
      end else begin
         tx_clock_lost <= tx_clock_lost_cond && ctrl_q.tx_clock_lost_pin_en;
      end
   end

   // Event sources for the status register, one bit each
   always_comb begin
      status_set    = '0;
      status_set[7] = rx_signaling_mf_pulse;
      status_set[6] = rx_align_frame_pulse;
      status_set[5] = tx_mf_pulse;
      status_set[4] = tick;
      status_set[3] = tx_align_frame_pulse;
      status_set[2] = tx_clock_lost_cond;
      status_set[1] = ctrl_q.csum_en ? rx_checksum_mf_pulse : free_mf_tick;
      status_set[0] = tx_slip_pulse;
   end

   // A read clears the bits it returned; a set in the same cycle wins
   assign status_clr = (req.rd && req.addr == `E1S_ADDR_EVT_STATUS) ? status_q : '0;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~status_clr) | status_set;
      end
   end

   // Interrupt request: any flag whose mask bit is 1
   always_comb begin
      irq = |(alarm_flags & alarm_mask_q)
         || |(status_q & event_mask_q);
   end

   // Receive line symbol decode
   assign mark     = rx_line.bit_en && (rx_line.pos ^ rx_line.neg);
   assign mark_pol = rx_line.pos;
   assign bipolar_violation      = mark && have_mark_q && (mark_pol == last_pol_q);
   // HDB3 violations follow 000V or B00V: two or three zeros before them;
   // a longer zero run is no codeword, so the run count stops at four
   assign hdb3_sub = bipolar_violation && (zeros_q == 3'd2 || zeros_q == 3'd3);

   always_comb begin
      if (ctrl_q.viol_type) begin
         viol_evt = bipolar_violation && have_v_q && (mark_pol == last_v_pol_q);
      end else begin
         viol_evt = bipolar_violation && !(ctrl_q.hdb3 && hdb3_sub);
      end
   end

   // Track last mark polarity, zeros since it, and last violation polarity
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         last_pol_q   <= 1'b0;
         have_mark_q  <= 1'b0;
         zeros_q      <= '0;
         last_v_pol_q <= 1'b0;
         have_v_q     <= 1'b0;
      end else if (rx_line.bit_en) begin
         if (mark) begin
            last_pol_q  <= mark_pol;
            have_mark_q <= 1'b1;
            zeros_q     <= '0;
         end else if (zeros_q != 3'd4) begin
            zeros_q <= zeros_q + 3'd1;
         end
         if (bipolar_violation) begin
            last_v_pol_q <= mark_pol;
            have_v_q     <= 1'b1;
         end
      end
   end

   // Violation accumulator: never gated by sync, saturates at all ones
   assign viol_acc_inc = (viol_acc_q == 16'hFFFF) ? viol_acc_q : viol_acc_q + 16'h0001;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         viol_acc_q <= '0;
         viol_cnt_q <= '0;
      end else if (tick) begin
         // An event on the boundary opens the new interval
         viol_cnt_q <= viol_acc_q;
         viol_acc_q <= viol_evt ? 16'h0001 : 16'h0000;
      end else if (viol_evt) begin
         viol_acc_q <= viol_acc_inc;
      end
   end

   // CRC4 error accumulator: at most 1000 per second, so no saturation
   assign csum_evt = checksum_error_pulse && !fas_sync_lost && !checksum_sync_lost;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         csum_acc_q <= '0;
         csum_cnt_q <= '0;
      end else if (tick) begin
         csum_cnt_q <= csum_acc_q;
         csum_acc_q <= 10'(csum_evt);
      end else if (csum_evt) begin
         csum_acc_q <= csum_acc_q + 10'd1;
      end
   end

   // Read data one cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rdata <= `E1S_RD_ZERO;
      end else if (req.rd) begin
         unique case (req.addr)
            `E1S_ADDR_VIOL_HI:    rdata <= viol_cnt_q[15:8];
            `E1S_ADDR_VIOL_LO:    rdata <= viol_cnt_q[7:0];
            `E1S_ADDR_CSUM_HI:    rdata <= {6'h00, csum_cnt_q[9:8]};
            `E1S_ADDR_CSUM_LO:    rdata <= csum_cnt_q[7:0];
            `E1S_ADDR_EVT_STATUS: rdata <= status_q;
            `E1S_ADDR_ALARM_MASK: rdata <= alarm_mask_q;
            `E1S_ADDR_EVENT_MASK: rdata <= event_mask_q;
            `E1S_ADDR_CTRL: begin
               rdata                        <= `E1S_RD_ZERO;
               rdata[`E1S_CTRL_TIMER_RATE]  <= ctrl_q.timer_rate;
               rdata[`E1S_CTRL_VIOL_TYPE]   <= ctrl_q.viol_type;
               rdata[`E1S_CTRL_HDB3]        <= ctrl_q.hdb3;
               rdata[`E1S_CTRL_TX_CLOCK_LOST_PIN_EN] <= ctrl_q.tx_clock_lost_pin_en;
               rdata[`E1S_CTRL_CSUM_EN]     <= ctrl_q.csum_en;
            end
            default: rdata <= `E1S_RD_ZERO;
         endcase
      end
   end

endmodule

`default_nettype wire

//--- e1s_status_sva.sv
/*
 * Port checker for the E1 status, mask and error-counter bank.
 * Assumes it is bound to e1s_status; writable registers are shadowed from port writes.
 */
`default_nettype none

module e1s_status_sva
   import e1s_pkg::*;
(
   input wire logic       mclk,
   input wire logic       reset,
   input wire e1s_req_t   req,
   input wire logic [7:0] rdata,
   input wire logic       tx_clock_input,
   input wire logic [7:0] alarm_flags,
   input wire logic       rx_signaling_mf_pulse,
   input wire logic       tx_slip_pulse,
   input wire logic       tx_clock_lost,
   input wire logic       irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] am_q;
   logic [7:0] em_q;
   logic [7:0] ct_q;
   logic [8:0] idle_q;
   logic       tc_q;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // Shadows land at the same edge as the bank's own registers
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         am_q <= 8'h00;
         em_q <= 8'h00;
         ct_q <= 8'h00;
      end else if (req.wr) begin
         case (req.addr)
            8'h16: am_q <= req.wdata;
            8'h17: em_q <= req.wdata;
            8'h18: ct_q <= req.wdata;
            default: ;
         endcase
      end
   end
   // Cycles since the transmit clock last moved; saturates so it never wraps to quiet
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tc_q   <= 1'b0;
         idle_q <= 9'h000;
      end else begin
         tc_q   <= tx_clock_input;
         idle_q <= (tx_clock_input != tc_q) ? 9'h000 : idle_q + {8'h00, ~&idle_q};
      end
   end
   a_alarm_irq_on: assert property (|(alarm_flags & am_q) |-> irq)
      else $error("irq low with an enabled alarm flag");
   a_event_irq_on: assert property (
      ((tx_slip_pulse & em_q[0]) | (rx_signaling_mf_pulse & em_q[7])) && !req.wr |=> irq)
      else $error("irq low after an enabled event");
   a_irq_quiet: assert property (am_q == 8'h00 && em_q == 8'h00 |-> !irq)
      else $error("irq high with all masks clear");
   a_alarm_mask_rd: assert property (req.rd && req.addr == 8'h16 |=> rdata == am_q)
      else $error("alarm mask read back wrong");
   a_event_mask_rd: assert property (req.rd && req.addr == 8'h17 |=> rdata == em_q)
      else $error("event mask read back wrong");
   a_unmapped_rd: assert property (
      req.rd && req.addr inside {[8'h04:8'h06], [8'h08:8'h15], [8'h19:8'hFF]}
      |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_csum_hi_pad: assert property (req.rd && req.addr == 8'h02 |=> rdata[7:2] == 6'h00)
      else $error("checksum count high byte padding not zero");
   a_lost_gated: assert property (!ct_q[1] && !$past(ct_q[1]) |-> !tx_clock_lost)
      else $error("lost clock pin high while disabled");
   a_lost_raised: assert property (
      idle_q > 9'd160 && ct_q[1] && $past(ct_q[1]) |-> tx_clock_lost)
      else $error("lost clock pin low after a silent channel time");
   a_lost_quiet: assert property (idle_q inside {[9'd3:9'd150]} |-> !tx_clock_lost)
      else $error("lost clock pin high too early");
endmodule

bind e1s_status e1s_status_sva e1s_status_sva_i (.mclk(mclk), .reset(reset), .req(req),
   .rdata(rdata), .tx_clock_input(tx_clock_input), .alarm_flags(alarm_flags),
   .rx_signaling_mf_pulse(rx_signaling_mf_pulse), .tx_slip_pulse(tx_slip_pulse),
   .tx_clock_lost(tx_clock_lost), .irq(irq));

`default_nettype wire

//--- e1s_host.sv
/*
 * Host model on the register port of the E1 status bank.
 * Assumes a shared mclk; read data stand from the cycle after the strobe until the next read.
 */
`default_nettype none

module e1s_host
   import e1s_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic [7:0] rdata,
   output var  e1s_req_t   req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   // One write cycle; idle address and data then change so stale values never pass
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask
   // Data taken at the edge that closes the answer cycle
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      req <= '{addr: a, wdata: ~req.wdata, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      req <= '{addr: ~a, wdata: req.wdata, wr: 1'b0, rd: 1'b0};
      @(posedge mclk);
      d = rdata;
   endtask
endmodule

`default_nettype wire

//--- testbench.sv
/*
 * Self-checking bench for the E1 status bank against an integer model.
 * Assumes the checker binds itself; timer intervals are shortened by parameter.
 */
`default_nettype none

module testbench
   import e1s_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SEC = 64;
   localparam int SUB = 16;
   localparam logic [7:0] MODES [3] = '{8'h01, 8'h05, 8'hC5};
   localparam logic [2:0] POS [6] = '{3'd0, 3'd1, 3'd3, 3'd5, 3'd6, 3'd7};
   logic       mclk, reset, txc, run_txc, tx_lost, irq, csum_err, fas_lost, csum_lost;
   logic [7:0] rdata, alarms, stat, ctrl;
   logic [5:0] pulse;
   e1s_line_t  line;
   e1s_req_t   req;
   int         error_cnt, checked, vacc, vlat, cacc, clat, bits, zrun, lastp, lastv;

   e1s_status #(.SEC_BITS(SEC), .SUBSEC_BITS(SUB)) e1s_status_i (.mclk(mclk), .reset(reset),
      .req(req), .rdata(rdata), .rx_line(line), .tx_clock_input(txc), .alarm_flags(alarms),
      .rx_signaling_mf_pulse(pulse[5]), .rx_align_frame_pulse(pulse[4]),
      .tx_mf_pulse(pulse[3]), .tx_align_frame_pulse(pulse[2]),
      .rx_checksum_mf_pulse(pulse[1]), .tx_slip_pulse(pulse[0]),
      .checksum_error_pulse(csum_err), .fas_sync_lost(fas_lost),
      .checksum_sync_lost(csum_lost), .tx_clock_lost(tx_lost), .irq(irq));
   e1s_host e1s_host_i (.mclk(mclk), .rdata(rdata), .req(req));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Transmit clock toggles every cycle unless a scenario silences it
   always @(posedge mclk) if (run_txc) txc <= ~txc;

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      e1s_host_i.reg_rd(a, d);
      check(d, e);
   endtask
   // Status read clears what it returns, so the model clears too
   task automatic stat_chk(input logic [7:0] m);
      logic [7:0] d;
      e1s_host_i.reg_rd(8'h07, d);
      check(d & m, stat & m);
      stat = 8'h00;
   endtask
   task automatic cnt_chk();
      rchk(8'h00, vlat[15:8]);
      rchk(8'h01, vlat[7:0]);
      rchk(8'h02, {6'h00, clat[9:8]});
      rchk(8'h03, clat[7:0]);
      stat_chk(8'hFF);
   endtask
   // One received bit with random marks, events and errors; sync levels move between bits
   task automatic send_bit(input logic [5:0] pm);
      int         m;
      logic [5:0] p;
      logic       e, ce, bipolar_violation, cv, v;
      m = $urandom_range(2);
      p = 6'($urandom & $urandom) & pm;
      e = 1'($urandom);
      bipolar_violation = m != 0 && m == lastp;
      cv = bipolar_violation && m == lastv;
      v = ctrl[6] ? cv : bipolar_violation && !(ctrl[2] && (zrun == 2 || zrun == 3));
      if (bipolar_violation) lastv = m;
      if (m != 0) lastp = m;
      zrun = (m != 0) ? 0 : zrun + 1;
      @(posedge mclk);
      // Sync levels read after the edge, as the bank will sample them
      ce = e && !fas_lost && !csum_lost;
      line <= '{bit_en: 1'b1, pos: m == 1, neg: m == 2};
      pulse <= p;
      csum_err <= e;
      @(posedge mclk);
      line <= '{default: 1'b0};
      pulse <= 6'h00;
      csum_err <= 1'b0;
      fas_lost <= ($urandom_range(7) == 0);
      csum_lost <= ($urandom_range(7) == 0);
      bits++;
      stat |= {p[5:3], 1'b0, p[2], 1'b0, p[1:0]};
      if (bits == (ctrl[7] ? SUB : SEC)) begin
         bits = 0;
         vlat = vacc;
         clat = cacc;
         vacc = v;
         cacc = ce;
         stat[4] = 1'b1;
      end else begin
         vacc += v;
         cacc += ce;
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      void'($urandom(4678));
      {reset, run_txc, txc, csum_err, fas_lost, csum_lost} = 6'b110000;
      {alarms, stat, ctrl, pulse} = 30'h0;
      line = '{default: 1'b0};
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      rchk(8'h16, 8'h00);
      rchk(8'h17, 8'h00);
      rchk(8'h0A, 8'h00);
      // Warm-up interval settles the polarity history before counts are compared
      ctrl = 8'h01;
      e1s_host_i.reg_wr(8'h18, ctrl);
      repeat (SEC) send_bit(6'h3F);
      stat_chk(8'hFF);
      $display("test reset and warm-up done");
      for (int i = 0; i < 3; i++) begin
         ctrl = MODES[i];
         e1s_host_i.reg_wr(8'h18, ctrl);
         rchk(8'h18, ctrl);
         repeat (2) begin
            repeat (ctrl[7] ? SUB : SEC) send_bit(6'h3F);
            e1s_host_i.reg_wr(8'h00, 8'hFF);
            cnt_chk();
         end
         $display("test counter mode %h done", ctrl);
      end
      // Each of the six pulsed event flags reaches irq through its own mask bit
      for (int i = 0; i < 6; i++) begin
         e1s_host_i.reg_wr(8'h17, 8'h01 << POS[i]);
         rchk(8'h17, 8'h01 << POS[i]);
         pulse <= 6'h01 << i;
         @(posedge mclk);
         pulse <= 6'h00;
         @(posedge mclk);
         check({7'h00, irq}, 8'h01);
         stat = 8'h01 << POS[i];
         stat_chk(8'hFF);
         check({7'h00, irq}, 8'h00);
      end
      e1s_host_i.reg_wr(8'h17, 8'h00);
      for (int i = 0; i < 8; i++) begin
         alarms <= 8'($urandom);
         e1s_host_i.reg_wr(8'h16, 8'h01 << i);
         rchk(8'h16, 8'h01 << i);
         check({7'h00, irq}, {7'h00, alarms[i]});
      end
      e1s_host_i.reg_wr(8'h16, 8'h00);
      $display("test interrupt masks done");
      // Silent transmit clock: flag always, pin only once enabled
      e1s_host_i.reg_wr(8'h17, 8'h04);
      run_txc <= 1'b0;
      repeat (200) @(posedge mclk);
      check({7'h00, tx_lost}, 8'h00);
      check({7'h00, irq}, 8'h01);
      ctrl = 8'hC7;
      e1s_host_i.reg_wr(8'h18, ctrl);
      repeat (3) @(posedge mclk);
      check({7'h00, tx_lost}, 8'h01);
      run_txc <= 1'b1;
      repeat (10) @(posedge mclk);
      check({7'h00, tx_lost}, 8'h00);
      stat = 8'h04;
      stat_chk(8'hFF);
      e1s_host_i.reg_wr(8'h17, 8'h00);
      $display("test lost transmit clock done");
      // Without CRC4 framing the multiframe flag still comes every 4096 bits
      ctrl = 8'h00;
      e1s_host_i.reg_wr(8'h18, ctrl);
      repeat (4096) send_bit(6'h00);
      stat[1] = 1'b1;
      cnt_chk();
      $display("test free-running multiframe done");
      close_out();
   end

   initial begin
      #(40000 * 25);
      error_cnt++;
      close_out();
   end
endmodule

`default_nettype wire
